// File: cfe_pkg.sv
// Constants, types and register map for the color expansion write stage
// Summary of operation
// - Mode field picks set/reset or expansion source
// - Selector bit picks rotated CPU byte or pattern
// - One bits give foreground, zero bits background
// - Foreground color from writable register FA
// - Background color from separate register FB
// - Pattern register F5 selects when chosen
// - Masked-write mask still clips final data
// - Bit mask still mixes expansion with latches
// - Write mode 3 ANDs rotated byte with mask
// - Reading F2 returns load sequence to plane 0
// - Four writes fill blue, green, red, intensity
// - Fast load uses no memory cycle, no waits
// - Load state increments mod four, read clears
// - Plane latches readable and writable individually
package cfe_pkg;

	// ************************************************************
	// Extension register indices
	// ************************************************************
	localparam logic [7:0] IDX_LATCH0 = 8'ha0;
	localparam logic [7:0] IDX_LOAD_STATE = 8'hf1;
	localparam logic [7:0] IDX_FAST_LOAD = 8'hf2;
	localparam logic [7:0] IDX_PATTERN = 8'hf5;
	localparam logic [7:0] IDX_FG_COLOR = 8'hfa;
	localparam logic [7:0] IDX_BG_COLOR = 8'hfb;
	localparam logic [7:0] IDX_CONTROL = 8'hfe;

	// ************************************************************
	// Field layout and encodings
	// ************************************************************
	localparam int CTL_MODE_LO = 2;
	localparam int CTL_SRC_BIT = 1;
	localparam logic [1:0] MODE_SET_RESET = 2'h0;
	localparam logic [1:0] MODE_EXPAND = 2'h1;
	localparam logic [1:0] WMODE_3 = 2'h3;
	localparam logic [1:0] LOAD_FIRST = 2'h0;
	localparam logic [1:0] LOAD_STEP = 2'h1;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	// Control register value split into its fields
	typedef struct packed {
		logic [3:0] unused;
		logic [1:0] mode;
		logic src_cpu;
		logic rsvd;
	} cfe_ctl_s;

	// One display memory write as handed to the memory sequencer
	typedef struct packed {
		logic [31:0] data;
		logic [7:0] wmask;
	} cfe_mem_wr_s;

endpackage

// File: cfe_plane_mix.sv
// One plane of the color expansion and bit mask mixing path
module cfe_plane_mix #(
	parameter int WIDTH = 8
) (
	// Sources
	input wire logic [WIDTH-1:0] set_reset_i,
	input wire logic [WIDTH-1:0] selector_i,
	input wire logic fg_bit_i,
	input wire logic bg_bit_i,
	input wire logic expand_i,
	// Mixing
	input wire logic [WIDTH-1:0] bit_mask_i,
	input wire logic [WIDTH-1:0] latch_i,
	output logic [WIDTH-1:0] data_o
);
	logic [WIDTH-1:0] fb_byte;
	logic [WIDTH-1:0] src_byte;

	assign fb_byte = (selector_i & {WIDTH{fg_bit_i}})
		| (~selector_i & {WIDTH{bg_bit_i}});
	assign src_byte = expand_i ? fb_byte : set_reset_i;
	// Bit mask mixes with latch contents
	assign data_o = (src_byte & bit_mask_i) | (latch_i & ~bit_mask_i);
endmodule // cfe_plane_mix

// File: cfe_color_expand.sv
// Color expansion, bit mask mixing and fast latch load for the write path
module cfe_color_expand #(
	parameter int PLANES = 4,
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Extension register port (index already decoded by the sequencer)
	input wire logic ext_wr_i,
	input wire logic ext_rd_i,
	input wire logic [7:0] ext_idx_i,
	input wire logic [7:0] ext_wdata_i,
	output logic [7:0] ext_rdata_o,
	output logic ext_rvalid_o,
	output logic ext_wait_o,
	// Display memory write request from the standard path
	input wire logic cpu_wr_i,
	input wire logic [WIDTH-1:0] rot_byte_i,
	input wire logic [PLANES*WIDTH-1:0] set_reset_i,
	input wire logic [WIDTH-1:0] bit_mask_i,
	input wire logic [1:0] write_mode_i,
	input wire logic [WIDTH-1:0] mw_mask_i,
	// Display memory read data for latching
	input wire logic mem_rd_i,
	input wire logic [PLANES*WIDTH-1:0] mem_rdata_i,
	// Result to memory
	output logic mem_wr_o,
	output cfe_pkg::cfe_mem_wr_s mem_o
);

	// ************************************************************
	// Elaboration check
	// ************************************************************
	generate
		if (PLANES != 4 || WIDTH != 8) begin : g_bad
			$error("cfe_color_expand serves four 8-bit planes only");
		end
	endgenerate

	// Index match, used for both read and write decode
	function automatic logic hit(input logic [7:0] idx,
		input logic [7:0] reg_idx);
		hit = (idx == reg_idx);
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0] pattern;
	logic [7:0] fg_color;
	logic [7:0] bg_color;
	cfe_pkg::cfe_ctl_s ctl;
	logic [1:0] load_state;
	logic [WIDTH-1:0] latch [PLANES];

	logic wr_fast;
	logic rd_fast;
	logic [1:0] next_load_state;
	logic expand;
	logic [WIDTH-1:0] selector;
	logic [WIDTH-1:0] eff_mask;
	logic [PLANES*WIDTH-1:0] mixed;
	logic [7:0] rd_mux;
	logic [1:0] lat_sel;
	logic lat_hit;

	assign wr_fast = ext_wr_i && hit(ext_idx_i, cfe_pkg::IDX_FAST_LOAD);
	assign rd_fast = ext_rd_i && hit(ext_idx_i, cfe_pkg::IDX_FAST_LOAD);
	assign lat_hit = (ext_idx_i[7:2] == cfe_pkg::IDX_LATCH0[7:2]);
	assign lat_sel = ext_idx_i[1:0];

	// Load state steps per write, a read clears it
	// Read of the fast load port restarts at plane 0
	assign next_load_state = rd_fast ? cfe_pkg::LOAD_FIRST
		: wr_fast ? load_state + cfe_pkg::LOAD_STEP : load_state;

	// Configuration registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pattern <= cfe_pkg::RST_BYTE;
			fg_color <= cfe_pkg::RST_BYTE;
			bg_color <= cfe_pkg::RST_BYTE;
			ctl <= cfe_pkg::RST_BYTE;
			load_state <= cfe_pkg::LOAD_FIRST;
		end else begin
			load_state <= next_load_state;
			if (ext_wr_i) begin
				if (hit(ext_idx_i, cfe_pkg::IDX_PATTERN)) begin
					pattern <= ext_wdata_i;
				end
				if (hit(ext_idx_i, cfe_pkg::IDX_FG_COLOR)) begin
					fg_color <= ext_wdata_i;
				end
				if (hit(ext_idx_i, cfe_pkg::IDX_BG_COLOR)) begin
					bg_color <= ext_wdata_i;
				end
				if (hit(ext_idx_i, cfe_pkg::IDX_CONTROL)) begin
					ctl <= ext_wdata_i;
				end
			end
		end
	end

	// ************************************************************
	// Plane latches
	// ************************************************************
	// A register write beats a memory read in the same cycle, so a
	// fast load is never overwritten by a stale read
	genvar p;
	generate
		for (p = 0; p < PLANES; p++) begin : g_latch
			logic ld_fast;
			logic ld_direct;
			assign ld_fast = wr_fast && (load_state == 2'(p));
			assign ld_direct = ext_wr_i && lat_hit && (lat_sel == 2'(p));
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					latch[p] <= cfe_pkg::RST_BYTE;
				// Successive bytes go to successive planes
				end else if (ld_fast || ld_direct) begin
					latch[p] <= ext_wdata_i;
				// Same latch as a memory read fills
				end else if (mem_rd_i) begin
					latch[p] <= mem_rdata_i[p*WIDTH +: WIDTH];
				end
			end
		end
	endgenerate

	// ************************************************************
	// Write data path
	// ************************************************************
	// Reserved codes fall back to set/reset
	assign expand = (ctl.mode == cfe_pkg::MODE_EXPAND);
	assign selector = ctl.src_cpu ? rot_byte_i : pattern;
	// Write mode 3 narrows the bit mask
	assign eff_mask = (write_mode_i == cfe_pkg::WMODE_3)
		? (rot_byte_i & bit_mask_i) : bit_mask_i;

	generate
		for (p = 0; p < PLANES; p++) begin : g_plane
			cfe_plane_mix #(
				.WIDTH(WIDTH)
			) u_mix (
				.set_reset_i(set_reset_i[p*WIDTH +: WIDTH]),
				.selector_i(selector),
				.fg_bit_i(fg_color[p]),
				.bg_bit_i(bg_color[p]),
				.expand_i(expand),
				.bit_mask_i(eff_mask),
				.latch_i(latch[p]),
				.data_o(mixed[p*WIDTH +: WIDTH])
			);
		end
	endgenerate

	// Memory write, one cycle after the request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_wr_o <= 1'b0;
			mem_o <= '0;
		end else begin
			mem_wr_o <= cpu_wr_i;
			if (cpu_wr_i) begin
				mem_o.data <= mixed;
				mem_o.wmask <= mw_mask_i;
			end
		end
	end

	// ************************************************************
	// Register read back
	// ************************************************************
	// Latches read back like any extension register
	assign rd_mux = lat_hit ? latch[lat_sel]
		: hit(ext_idx_i, cfe_pkg::IDX_PATTERN) ? pattern
		: hit(ext_idx_i, cfe_pkg::IDX_FG_COLOR) ? fg_color
		: hit(ext_idx_i, cfe_pkg::IDX_BG_COLOR) ? bg_color
		: hit(ext_idx_i, cfe_pkg::IDX_CONTROL) ? ctl
		: hit(ext_idx_i, cfe_pkg::IDX_LOAD_STATE) ? {6'h00, load_state}
		: cfe_pkg::READ_NONE;

	// Reads answer one cycle later; no memory cycle is ever involved
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_rdata_o <= cfe_pkg::READ_NONE;
			ext_rvalid_o <= 1'b0;
			ext_wait_o <= 1'b0;
		end else begin
			ext_rvalid_o <= ext_rd_i;
			// Register path never stalls the host
			ext_wait_o <= 1'b0;
			if (ext_rd_i) begin
				ext_rdata_o <= rd_mux;
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_read_clears_state: assert property (
		rd_fast |=> load_state == cfe_pkg::LOAD_FIRST)
		else $error("fast load read did not clear state");
	chk_state_steps: assert property (
		wr_fast && !rd_fast |=> load_state == $past(load_state) + 2'h1)
		else $error("load state did not step");
	chk_fast_fill: assert property (
		wr_fast && load_state == cfe_pkg::LOAD_FIRST
		|=> latch[0] == $past(ext_wdata_i))
		else $error("first fast load byte missed plane 0");
	chk_no_mem_cycle: assert property (
		wr_fast && !cpu_wr_i |=> !mem_wr_o && !ext_wait_o)
		else $error("fast load caused memory cycle or wait");
	chk_expand_color: assert property (
		cpu_wr_i && expand && ctl.src_cpu && rot_byte_i[0]
		&& eff_mask[0] |=> mem_o.data[0] == $past(fg_color[0]))
		else $error("expanded one bit not foreground");
	chk_pattern_src: assert property (
		cpu_wr_i && expand && !ctl.src_cpu && !pattern[7]
		&& eff_mask[7] |=> mem_o.data[7] == $past(bg_color[0]))
		else $error("pattern zero bit not background");
	chk_reserved_mode: assert property (
		cpu_wr_i && !expand && bit_mask_i == 8'hff
		&& write_mode_i != cfe_pkg::WMODE_3
		|=> mem_o.data == $past(set_reset_i))
		else $error("reserved mode not set/reset");
	chk_mask_latch: assert property (
		cpu_wr_i && eff_mask == 8'h00 |=> mem_o.data[7:0] == $past(latch[0]))
		else $error("masked bits not from latch");
	chk_wm3_mask: assert property (
		cpu_wr_i && write_mode_i == cfe_pkg::WMODE_3 && rot_byte_i == 8'h00
		|=> mem_o.data[15:8] == $past(latch[1]))
		else $error("write mode 3 mask not ANDed");
	chk_clip_mask: assert property (
		cpu_wr_i |=> mem_o.wmask == $past(mw_mask_i))
		else $error("masked write mask lost");

	cov_fast_load: cover property (rd_fast ##[1:4] wr_fast ##[1:4] wr_fast
		##[1:4] wr_fast ##[1:4] wr_fast);
	cov_expand_wr: cover property (cpu_wr_i && expand);
	cov_wm3_expand: cover property (cpu_wr_i && expand
		&& write_mode_i == cfe_pkg::WMODE_3);
endmodule // cfe_color_expand

// File: cfe_host.sv
// Host CPU model driving the extension register port
module cfe_host (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] idx_o,
	output logic [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		idx_o = 8'h00;
		wdata_o = 8'h00;
	end

	// One strobe cycle; released lines show the inverse so stale data
	// can never pass for a real value
	task automatic access(input logic w, input logic [7:0] i,
			input logic [7:0] d);
		@(negedge clk_i);
		wr_o = w;
		rd_o = !w;
		idx_o = i;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		idx_o = ~i;
		wdata_o = ~d;
	endtask

	task automatic load_latches(input logic [31:0] d);
		access(1'b0, cfe_pkg::IDX_FAST_LOAD, 8'h00);
		for (int p = 0; p < 4; p++) begin
			access(1'b1, cfe_pkg::IDX_FAST_LOAD, d[8*p +: 8]);
		end
	endtask
endmodule // cfe_host

// File: color_expand_latch_load_bench.sv
// Self-checking bench for the color expansion write stage
module color_expand_latch_load_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ext_wr, ext_rd, cpu_wr_i, mem_rd_i, ext_rvalid_o, ext_wait_o, mem_wr_o;
	logic [7:0] ext_idx, ext_wdata, ext_rdata_o, rot_byte_i, bit_mask_i;
	logic [7:0] mw_mask_i, fg, bg, pat, ctl;
	logic [1:0] write_mode_i;
	logic [31:0] set_reset_i, mem_rdata_i, lat;
	cfe_pkg::cfe_mem_wr_s mem_o;
	logic [7:0] q_rd[$];
	cfe_pkg::cfe_mem_wr_s q_mem[$];
	logic [39:0] exp_v;
	logic [7:0] idx_tab[11] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'hf1, 8'hf2,
		8'hf5, 8'hfa, 8'hfb, 8'hfe, 8'h10};
	integer seed = 32'h735d839a;
	int failures = 0;
	int n_checks = 0;

	always #25 clk_i = ~clk_i;

	cfe_host host (.clk_i(clk_i), .wr_o(ext_wr), .rd_o(ext_rd),
		.idx_o(ext_idx), .wdata_o(ext_wdata));

	cfe_color_expand uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_wr_i(ext_wr),
		.ext_rd_i(ext_rd), .ext_idx_i(ext_idx), .ext_wdata_i(ext_wdata),
		.ext_rdata_o(ext_rdata_o), .ext_rvalid_o(ext_rvalid_o),
		.ext_wait_o(ext_wait_o), .cpu_wr_i(cpu_wr_i), .rot_byte_i(rot_byte_i),
		.set_reset_i(set_reset_i), .bit_mask_i(bit_mask_i),
		.write_mode_i(write_mode_i), .mw_mask_i(mw_mask_i),
		.mem_rd_i(mem_rd_i), .mem_rdata_i(mem_rdata_i),
		.mem_wr_o(mem_wr_o), .mem_o(mem_o));

	task automatic check(input logic [39:0] s, input logic [39:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic tally_and_finish();
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Reads note their answer first; the watcher compares it later
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		q_rd.push_back(e);
		host.access(1'b0, i, 8'h00);
	endtask

	// Independent reference of the whole write data path
	function automatic cfe_pkg::cfe_mem_wr_s calc();
		cfe_pkg::cfe_mem_wr_s r;
		logic [7:0] sel, m, s;
		sel = ctl[1] ? rot_byte_i : pat;
		m = (write_mode_i == 2'h3) ? (rot_byte_i & bit_mask_i) : bit_mask_i;
		for (int p = 0; p < 4; p++) begin
			if (ctl[3:2] == 2'h1)
				s = (sel & {8{fg[p]}}) | (~sel & {8{bg[p]}});
			else
				s = set_reset_i[8*p +: 8];
			r.data[8*p +: 8] = (s & m) | (lat[8*p +: 8] & ~m);
		end
		r.wmask = mw_mask_i;
		return r;
	endfunction

	// Watcher: results settle at the rising edge, looked at on the falling
	always @(negedge clk_i) begin
		if (rst_n_i) begin
			check(40'(ext_wait_o), 40'h0);
			// An answer with no note is a mismatch by construction
			if (ext_rvalid_o) begin
				exp_v = (q_rd.size() > 0) ? 40'(q_rd.pop_front())
					: 40'h1ff;
				check(40'(ext_rdata_o), exp_v);
			end
			if (mem_wr_o) begin
				exp_v = (q_mem.size() > 0) ? 40'(q_mem.pop_front())
					: ~40'(mem_o);
				check(40'(mem_o), exp_v);
			end
		end
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		tally_and_finish();
	end

	initial begin
		{cpu_wr_i, mem_rd_i, rot_byte_i, bit_mask_i, mw_mask_i} = '0;
		{write_mode_i, set_reset_i, mem_rdata_i, lat, fg, bg, pat, ctl} = '0;
		repeat (12) @(negedge clk_i);
		rst_n_i = 1'b1;
		// reset values, fast-load port and unmapped index read zero
		foreach (idx_tab[k]) rd(idx_tab[k], 8'h00);
		// fast load then readback of each plane
		lat = 32'($random(seed));
		// The restarting read of the fast-load port answers zero
		q_rd.push_back(8'h00);
		host.load_latches(lat);
		for (int p = 0; p < 4; p++) rd(8'ha0 + 8'(p), lat[8*p +: 8]);
		lat[7:0] = 8'h5a;
		host.access(1'b1, cfe_pkg::IDX_FAST_LOAD, 8'h5a);
		rd(cfe_pkg::IDX_LOAD_STATE, 8'h01);
		rd(cfe_pkg::IDX_LATCH0, 8'h5a);
		rd(cfe_pkg::IDX_FAST_LOAD, 8'h00);
		rd(cfe_pkg::IDX_LOAD_STATE, 8'h00);
		host.access(1'b1, 8'h10, 8'hff);
		rd(8'h10, 8'h00);
		// every mode, source and write mode
		for (int c = 0; c < 64; c++) begin
			fg = 8'($random(seed));
			bg = 8'($random(seed));
			pat = 8'($random(seed));
			ctl = {4'h0, 2'(c), 1'(c >> 2), 1'b0};
			host.access(1'b1, cfe_pkg::IDX_FG_COLOR, fg);
			host.access(1'b1, cfe_pkg::IDX_BG_COLOR, bg);
			host.access(1'b1, cfe_pkg::IDX_PATTERN, pat);
			host.access(1'b1, cfe_pkg::IDX_CONTROL, ctl);
			// memory-read latches mix like fast-loaded ones
			if (c % 8 == 0) begin
				@(negedge clk_i);
				mem_rd_i = 1'b1;
				mem_rdata_i = 32'($random(seed));
				lat = mem_rdata_i;
				@(negedge clk_i);
				mem_rd_i = 1'b0;
			end
			@(negedge clk_i);
			cpu_wr_i = 1'b1;
			rot_byte_i = 8'($random(seed));
			set_reset_i = 32'($random(seed));
			bit_mask_i = 8'($random(seed));
			mw_mask_i = 8'($random(seed));
			write_mode_i = 2'(c >> 3);
			// Directed corners: full bit mask, and an empty mode 3 mask
			if (c % 4 == 2) begin
				bit_mask_i = 8'hff;
			end
			if (c % 4 == 3) begin
				rot_byte_i = 8'h00;
			end
			q_mem.push_back(calc());
			@(negedge clk_i);
			cpu_wr_i = 1'b0;
		end
		rd(cfe_pkg::IDX_CONTROL, ctl);
		rd(cfe_pkg::IDX_FG_COLOR, fg);
		rd(cfe_pkg::IDX_BG_COLOR, bg);
		rd(cfe_pkg::IDX_PATTERN, pat);
		for (int w = 0; w < 10 && (q_rd.size() + q_mem.size()) > 0; w++)
			@(negedge clk_i);
		if ((q_rd.size() + q_mem.size()) > 0)
			failures++;
		tally_and_finish();
	end
endmodule // color_expand_latch_load_bench
